/* pixel_skip_map.vh */
`ifndef PIXEL_SKIP_MAP_VH
`define PIXEL_SKIP_MAP_VH
// ****************************************
// instruction word layout
// ****************************************
`define OPC_HI 31
`define OPC_LO 28
`define OPC_PACKED_SKIP 4'h2
`define OPC_PLANAR_SKIP 4'ha
`define CNT1_HI 11
`define CNT1_LO 0
`define CNT2_HI 11
`define CNT2_LO 0
`define CNT3_HI 27
`define CNT3_LO 16
`define STS_SET_HI 23
`define STS_SET_LO 20
`define STS_CLR_HI 19
`define STS_CLR_LO 16
`define IRQ_BIT 24
`define LINE_END_BIT 26
`define LINE_START_BIT 27
// ****************************************
// register map, byte addresses
// ****************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_DONE_CNT 4'h8
`define CTRL_ENABLE 0
`define CTRL_CLR_ERR 1
`define CTRL_RESET 32'h0000_0000
`define STAT_BUSY 8
`define STAT_ABORTING 9
`define STAT_ERR_OPC 10
`define STAT_ERR_LINE 11
`define STAT_ERR_EOL 12
// ****************************************
// fifo word geometry
// ****************************************
`define BYTES_PER_WORD 3'h4
`endif

/* byte_skipper.v */
`timescale 1ns/10ps
`default_nettype none
`include "pixel_skip_map.vh"
// discards a byte count from one fifo, byte lane by byte lane
module byte_skipper #(
  parameter CW = 12
) (
  input wire clk_i,
  input wire reset_i,
  input wire start_i, // load a new count
  input wire [CW-1:0] count_i,
  input wire line_end_i, // instruction carries line end mark
  input wire flush_i, // drop what is left
  input wire fifo_valid_i,
  input wire fifo_eol_i, // current word is last of line
  output wire fifo_pop_o,
  output wire busy_o,
  output wire early_eol_o
);
  reg [CW-1:0] remaining; // bytes still to drop
  reg [1:0] lane; // next byte lane in head word
  wire [2:0] avail; // bytes left in head word
  wire word_done; // this cycle eats the rest of the word
  wire active;
  assign avail = `BYTES_PER_WORD - {1'b0, lane};
  assign active = (remaining != {CW{1'b0}}) && fifo_valid_i && !flush_i;
  assign word_done = remaining >= {{(CW-3){1'b0}}, avail};
  // line ended under us: last word used up by an unmarked skip, or more bytes
  // wanted than remain; an unmarked skip may still stop inside the last word
  assign early_eol_o = active && fifo_eol_i && word_done && (!line_end_i ||
    (remaining > {{(CW-3){1'b0}}, avail}));
  assign fifo_pop_o = active && (word_done || early_eol_o);
  assign busy_o = (remaining != {CW{1'b0}});
  // ****************************************
  // byte-granular consumption
  // ****************************************
  always @(posedge clk_i) begin
    if (reset_i) begin
      remaining <= {CW{1'b0}};
      lane <= 2'h0;
    end else if (start_i) begin
      remaining <= count_i;
    end else if (flush_i) begin
      remaining <= {CW{1'b0}};
    end else if (active) begin
      if (early_eol_o) begin
        // rest of the line is gone, restart at lane 0
        remaining <= {CW{1'b0}};
        lane <= 2'h0;
      end else if (word_done) begin
        remaining <= remaining - {{(CW-3){1'b0}}, avail};
        lane <= 2'h0;
      end else begin
        // stop mid word; next instruction continues from here
        remaining <= {CW{1'b0}};
        lane <= lane + remaining[1:0];
      end
    end
  end
endmodule
`default_nettype wire

/* pixel_skip_engine.v */
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pixel_skip_map.vh"
// Operation
// - packed skip drops bits 11:0 bytes
// - skips start and stop at any byte
// - planar skip drops word0 count from fifo1
// - word1 counts feed fifo2 and fifo3
// - apply status set/clear on execution
// - line start and end flags frame lines
// - early fifo eol aborts through line end
module pixel_skip_engine #(
  parameter CW = 12,
  parameter SW = 4
) (
  input wire clk_i,
  input wire reset_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // instruction words from fetch/decode
  input wire instr_valid_i,
  input wire [31:0] instr_word_i,
  output wire instr_ready_o,
  // three pixel fifos, index 0 is luma/packed
  input wire [2:0] fifo_valid_i,
  input wire [2:0] fifo_eol_i,
  output wire [2:0] fifo_pop_o,
  // sequencer side effects
  output reg [SW-1:0] program_status_bits_o,
  output reg irq_o,
  output reg line_start_flag_o,
  output reg line_end_flag_o
);
  localparam ST_IDLE = 2'h0; // wait first word
  localparam ST_WORD1 = 2'h1; // wait planar second word
  localparam ST_RUN = 2'h2; // discarding
  localparam ST_ABORT = 2'h3; // dropping instructions to line end
  reg [1:0] state;
  reg [31:0] word0; // held first word
  reg [31:0] ctrl;
  reg [2:0] err; // sticky error bits, status[12:10]
  reg swallow; // second word of a dropped planar skip still due
  reg [31:0] done_cnt; // completed instructions
  reg in_line; // between line start and line end
  reg ack; // one cycle answer of the bus
  reg [2:0] start;
  reg [CW-1:0] cnt0;
  reg [CW-1:0] cnt1;
  reg [CW-1:0] cnt2;
  reg flush;
  wire [2:0] busy;
  wire [2:0] early;
  wire [3:0] opc;
  wire take;
  wire enable;
  assign enable = ctrl[`CTRL_ENABLE];
  assign opc = instr_word_i[`OPC_HI:`OPC_LO];
  assign instr_ready_o = enable && (state != ST_RUN);
  assign take = instr_valid_i && instr_ready_o;
  // ****************************************
  // status bit update
  // ****************************************
  // set nibble wins over clear nibble for the same bit
  function [SW-1:0] next_status;
    input [SW-1:0] cur;
    input [31:0] w;
    begin
      next_status = (cur & ~w[`STS_CLR_HI:`STS_CLR_LO]) | w[`STS_SET_HI:`STS_SET_LO];
    end
  endfunction
  // ****************************************
  // discard engines, one per fifo
  // ****************************************
  byte_skipper #(.CW(CW)) u_skip0 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(start[0]),
    .count_i(cnt0),
    .line_end_i(word0[`LINE_END_BIT]),
    .flush_i(flush),
    .fifo_valid_i(fifo_valid_i[0]),
    .fifo_eol_i(fifo_eol_i[0]),
    .fifo_pop_o(fifo_pop_o[0]),
    .busy_o(busy[0]),
    .early_eol_o(early[0])
  );
  byte_skipper #(.CW(CW)) u_skip1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(start[1]),
    .count_i(cnt1),
    .line_end_i(word0[`LINE_END_BIT]),
    .flush_i(flush),
    .fifo_valid_i(fifo_valid_i[1]),
    .fifo_eol_i(fifo_eol_i[1]),
    .fifo_pop_o(fifo_pop_o[1]),
    .busy_o(busy[1]),
    .early_eol_o(early[1])
  );
  byte_skipper #(.CW(CW)) u_skip2 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(start[2]),
    .count_i(cnt2),
    .line_end_i(word0[`LINE_END_BIT]),
    .flush_i(flush),
    .fifo_valid_i(fifo_valid_i[2]),
    .fifo_eol_i(fifo_eol_i[2]),
    .fifo_pop_o(fifo_pop_o[2]),
    .busy_o(busy[2]),
    .early_eol_o(early[2])
  );
  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      word0 <= 32'h0000_0000;
      start <= 3'h0;
      cnt0 <= {CW{1'b0}};
      cnt1 <= {CW{1'b0}};
      cnt2 <= {CW{1'b0}};
      flush <= 1'b0;
      program_status_bits_o <= {SW{1'b0}};
      irq_o <= 1'b0;
      line_start_flag_o <= 1'b0;
      line_end_flag_o <= 1'b0;
      done_cnt <= 32'h0000_0000;
      in_line <= 1'b0;
      err <= 3'h0;
      swallow <= 1'b0;
    end else begin
      // pulses by default
      start <= 3'h0;
      flush <= 1'b0;
      irq_o <= 1'b0;
      line_start_flag_o <= 1'b0;
      line_end_flag_o <= 1'b0;
      // software clear first, hardware set below wins
      if (avs_write_i && ack && avs_address_i == `REG_CTRL &&
          avs_writedata_i[`CTRL_CLR_ERR]) begin
        err <= 3'h0;
      end
      case (state)
        ST_IDLE: begin
          if (take) begin
            word0 <= instr_word_i;
            if (opc == `OPC_PACKED_SKIP) begin
              cnt0 <= instr_word_i[`CNT1_HI:`CNT1_LO];
              start <= 3'h7; // fifos 2,3 get zero counts
              cnt1 <= {CW{1'b0}};
              cnt2 <= {CW{1'b0}};
              state <= ST_RUN;
            end else if (opc == `OPC_PLANAR_SKIP) begin
              cnt0 <= instr_word_i[`CNT1_HI:`CNT1_LO];
              state <= ST_WORD1;
            end else begin
              err[`STAT_ERR_OPC-10] <= 1'b1; // not a skip, dropped
            end
            // line start while a line is open breaks framing
            if (instr_word_i[`LINE_START_BIT]) begin
              line_start_flag_o <= 1'b1;
              if (in_line) begin
                err[`STAT_ERR_LINE-10] <= 1'b1;
              end
              in_line <= 1'b1;
            end
          end
        end
        ST_WORD1: begin
          if (take && swallow) begin
            // counts of an aborted planar skip: no discard, no side effects
            swallow <= 1'b0;
            state <= ST_IDLE;
          end else if (take) begin
            cnt1 <= instr_word_i[`CNT2_HI:`CNT2_LO];
            cnt2 <= instr_word_i[`CNT3_HI:`CNT3_LO];
            start <= 3'h7;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (|early) begin
            // line cut short: side effects of this instruction are lost
            flush <= 1'b1;
            err[`STAT_ERR_EOL-10] <= 1'b1;
            in_line <= 1'b0;
            state <= word0[`LINE_END_BIT] ? ST_IDLE : ST_ABORT;
          end else if (start == 3'h0 && busy == 3'h0) begin
            program_status_bits_o <= next_status(program_status_bits_o, word0);
            irq_o <= word0[`IRQ_BIT];
            if (word0[`LINE_END_BIT]) begin
              line_end_flag_o <= 1'b1;
              in_line <= 1'b0;
            end
            done_cnt <= done_cnt + 32'h0000_0001;
            state <= ST_IDLE;
          end
        end
        ST_ABORT: begin
          // planar second words carry no mark; opcode check keeps them apart
          if (take && (opc == `OPC_PACKED_SKIP || opc == `OPC_PLANAR_SKIP) &&
              instr_word_i[`LINE_END_BIT]) begin
            state <= (opc == `OPC_PLANAR_SKIP) ? ST_WORD1 : ST_IDLE;
            swallow <= (opc == `OPC_PLANAR_SKIP); // its second word is dropped too
            word0 <= 32'h0000_0000; // no stale marks left behind
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // a stale first-fifo count would run again if word1 were not swallowed
    end
  end
  // ****************************************
  // avalon-mm slave, one wait cycle per access
  // ****************************************
  // waitrequest drops one cycle after a request appears
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  always @(posedge clk_i) begin
    if (reset_i) begin
      ack <= 1'b0;
      ctrl <= `CTRL_RESET;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
      if (avs_write_i && ack && avs_address_i == `REG_CTRL) begin
        // clear bit is a strobe and is not stored
        ctrl <= {31'h0000_0000, avs_writedata_i[`CTRL_ENABLE]};
      end
      if (avs_read_i && !ack) begin
        case (avs_address_i)
          `REG_CTRL: avs_readdata_o <= ctrl;
          `REG_STATUS: begin
            avs_readdata_o <= {19'h00000, err[2:0], (state == ST_ABORT),
              (state != ST_IDLE), 4'h0, {(4-SW){1'b0}}, program_status_bits_o};
          end
          `REG_DONE_CNT: avs_readdata_o <= done_cnt;
          default: avs_readdata_o <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* skip_checker_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// checker on the engine's ports
// ****
module skip_checker #(
  parameter SW = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_word_i,
  input wire logic instr_ready_o,
  input wire logic [2:0] fifo_valid_i,
  input wire logic [2:0] fifo_pop_o,
  input wire logic [SW-1:0] program_status_bits_o,
  input wire logic irq_o,
  input wire logic line_start_flag_o,
  input wire logic line_end_flag_o
);
  logic tk; // word handed over
  logic pend; // planar second word still due
  logic pk; // packed skip is the one running
  assign tk = instr_valid_i && instr_ready_o;
  // track the word sequence so the second planar word is not read as an opcode
  always @(posedge clk_i) begin
    if (reset_i) begin
      pend <= 1'b0;
      pk <= 1'b0;
    end else if (tk) begin
      pend <= !pend && instr_word_i[31:28] == 4'ha;
      pk <= !pend && instr_word_i[31:28] == 4'h2;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_pulse_done;
    instr_ready_o ##1 !line_end_flag_o;
  endsequence
  wait_first_a: assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o) else $error("bus request answered at once");
  pop_valid_a: assert property ((fifo_pop_o & ~fifo_valid_i) == 3'h0)
    else $error("pop from an empty fifo");
  packed_pop_a: assert property (pk |-> fifo_pop_o[2:1] == 2'h0)
    else $error("packed skip touched a chroma fifo");
  planar_next_a: assert property (tk && !pend && instr_word_i[31:28] == 4'ha
    |=> instr_ready_o) else $error("second planar word not accepted");
  status_when_a: assert property (!$stable(program_status_bits_o) |-> instr_ready_o)
    else $error("status bits changed mid instruction");
  line_start_a: assert property (tk && !pend && instr_word_i[27] |=> line_start_flag_o)
    else $error("line start mark not flagged");
  line_end_a: assert property (line_end_flag_o |-> s_pulse_done)
    else $error("line end flag badly timed");
  irq_pulse_a: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
endmodule
bind pixel_skip_engine skip_checker #(.SW(SW)) i_skip_checker (.clk_i(clk_i), .reset_i(reset_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .instr_ready_o(instr_ready_o),
  .fifo_valid_i(fifo_valid_i), .fifo_pop_o(fifo_pop_o),
  .program_status_bits_o(program_status_bits_o), .irq_o(irq_o),
  .line_start_flag_o(line_start_flag_o), .line_end_flag_o(line_end_flag_o));
`default_nettype wire

/* fifo_model.sv */
`timescale 1ns/10ps
`default_nettype none
// three pixel fifos; word index eol_word_i is the last of a line
module fifo_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic stall_i,
  input wire logic [15:0] eol_word_i,
  input wire logic [2:0] pop_i,
  output logic [2:0] valid_o,
  output logic [2:0] eol_o,
  output logic [47:0] pops_o
);
  // head index equals words popped so far
  always @(posedge clk_i) begin
    if (reset_i) begin
      pops_o <= 48'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pop_i[i] && valid_o[i]) begin
          pops_o[16*i+:16] <= pops_o[16*i+:16] + 16'h1;
        end
      end
    end
  end
  // a stalled fifo shows no head word and no end mark
  always_comb begin
    valid_o = stall_i ? 3'h0 : 3'h7;
    for (int i = 0; i < 3; i++) begin
      eol_o[i] = valid_o[i] && pops_o[16*i+:16] == eol_word_i;
    end
  end
endmodule
`default_nettype wire

/* dma_pixel_skip_instructions_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dma_pixel_skip_instructions_tb;
  logic clk_i = 0, reset_i = 1, rd = 0, wr = 0, iv = 0, stall = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, iw = 32'h0, rdat, rdata;
  logic [15:0] eolw = 16'hffff;
  logic wreq, ird, irq, ls, le;
  logic [2:0] fv, fe, fp;
  logic [3:0] sts;
  logic [47:0] pops;
  int miscompares = 0, checks_done = 0, cyc = 0, n_irq = 0, n_ls = 0, n_le = 0;
  always #10 clk_i = ~clk_i;
  // fifo stalls every fifth cycle; hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    stall <= (cyc % 5 == 0);
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  // pulses counted mid-cycle where they are settled
  always @(negedge clk_i) begin
    n_irq += irq;
    n_ls += ls;
    n_le += le;
  end
  pixel_skip_engine i_pixel_skip_engine (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .instr_valid_i(iv), .instr_word_i(iw), .instr_ready_o(ird),
    .fifo_valid_i(fv), .fifo_eol_i(fe), .fifo_pop_o(fp), .program_status_bits_o(sts),
    .irq_o(irq), .line_start_flag_o(ls), .line_end_flag_o(le));
  fifo_model i_fifo_model (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall),
    .eol_word_i(eolw), .pop_i(fp), .valid_o(fv), .eol_o(fe), .pops_o(pops));
  task chk(input string n, input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until the rising edge where waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    while (wreq !== 1'b0) @(posedge clk_i);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge, so a following call never re-raises in this step
    @(posedge clk_i);
  endtask
  // offer a word until taken, then wait until the engine is free again
  task ins(input logic [31:0] w);
    iv <= 1'b1;
    iw <= w;
    @(posedge clk_i);
    while (ird !== 1'b1) @(posedge clk_i);
    iv <= 1'b0;
    @(posedge clk_i);
    while (ird !== 1'b1) @(posedge clk_i);
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, 4'h4, 32'h0);
    chk("status", rdat, 32'h0);
    bus(0, 4'hc, 32'h0);
    chk("unmapped", rdat, 32'h0);
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h0, 32'h0);
    chk("ctrl", rdat, 32'h1);
    // whole line in one skip, then odd lane starts and stops
    ins(32'h2da0_0006);
    ins(32'h2000_0002);
    ins(32'h2000_0009);
    ins(32'h2000_0003);
    chk("pops", pops, 48'h5);
    chk("marks", {n_irq[3:0], n_ls[3:0], n_le[3:0]}, 12'h111);
    chk("sts", sts, 4'ha);
    ins(32'h2012_0000);
    chk("sts", sts, 4'h9);
    ins(32'ha500_0008);
    ins(32'h0004_0004); // equal chroma counts
    chk("pops", pops, 48'h0001_0001_0007);
    chk("marks", {n_irq[3:0], n_le[3:0]}, 8'h22);
    // fifo ends the line early; skips dropped through the line end mark
    eolw <= 16'd8;
    ins(32'h2000_000c);
    eolw <= 16'hffff;
    ins(32'h2000_0004);
    ins(32'ha420_0004); // planar with line end: both words dropped
    ins(32'h0004_0004);
    ins(32'h2040_0004);
    chk("pops", pops, 48'h0001_0001_000a);
    chk("marks", n_le[3:0], 4'h2);
    bus(0, 4'h4, 32'h0);
    chk("status", rdat, 32'h0000_100d);
    ins(32'h7000_0000);
    bus(0, 4'h4, 32'h0);
    chk("status", rdat, 32'h0000_140d);
    bus(1, 4'h0, 32'h3);
    // unmarked skip stops inside the line's last word; the marked one ends it
    eolw <= 16'd11;
    ins(32'h2000_0006);
    ins(32'h2400_0002);
    chk("pops", pops, 48'h0001_0001_000c);
    chk("marks", n_le[3:0], 4'h3);
    bus(0, 4'h4, 32'h0);
    chk("status", rdat, 32'h0000_000d);
    bus(0, 4'h8, 32'h0);
    chk("done", rdat, 32'h9);
    summarize();
  end
endmodule
`default_nettype wire
